// [design/lpm_ctrl.sv]
// Purpose: Low-power mode controller with AXI4-Lite registers
// Assumes: LP_REQ and PERIPH_EVENT are synchronous to CLK
// Notes:   Wakeup pins pass a two-stage synchroniser
// Summary of operation
// - Light sleep stops only the processor clock
// - Peripheral interrupt or event ends light sleep
// - Deep stop gates all core-domain clocks
// - Deep stop disables PLL and fast oscillators
// - Deep stop keeps memory and registers powered
// - Deep stop regulator: main/low-power, normal/under-drive
// - Any extended interrupt line ends deep stop
// - Standby removes regulator, core power, oscillators
// - Standby loses state except backup domain
// - Reset pin, watchdog, wake pin, clock end standby
// - No standby while regulator is bypassed
`timescale 1ns/1ps
module lpm_ctrl #(
  parameter int LINE_CNT = 16
) (
  // Clock, reset and enable
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                CE,
  // AXI4-Lite write channels
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [7:0]          AWADDR,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  // AXI4-Lite read channels
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [7:0]          ARADDR,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  // Processor side
  input  wire logic                LP_REQ,
  input  wire logic                PERIPH_EVENT,
  // Wakeup sources and regulator bypass status
  input  wire logic [LINE_CNT-1:0] EXTERNAL_INTERRUPT_LINE,
  input  wire logic                SUPPLY_VOLTAGE_DETECTOR,
  input  wire logic [3:0]          RTC_EVENT,
  input  wire logic                USB_WAKE,
  input  wire logic                ETH_WAKE,
  input  wire logic                RESET_PIN_LOW,
  input  wire logic                INDEPENDENT_WATCHDOG,
  input  wire logic                WAKE_PIN,
  input  wire logic                REG_BYPASS,
  // Clock and power controls
  output logic                     CPU_CLK_EN,
  output logic                     CORE_CLK_EN,
  output logic                     PLL_EN,
  output logic                     INTERNAL_FAST_RC_OSC_EN,
  output logic                     EXTERNAL_FAST_CRYSTAL_OSC_EN,
  output logic                     MAIN_REGULATOR_EN,
  output logic                     LOW_POWER_REGULATOR_EN,
  output logic                     UNDER_DRIVE,
  output logic                     CORE_POWER_EN,
  output logic                     CORE_RESET_N,
  output logic                     BACKUP_RAM_RETAIN
);

  typedef struct packed {
    lpm_pkg::lpm_state_type          state;
    logic [lpm_pkg::CTRL_WIDTH-1:0] ctrl;
    logic                            refused;
    logic                            sb_woke;
    logic [7:0]                      cnt;
    logic                            aw_got;
    logic [7:0]                      aw_addr;
    logic                            w_got;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            awready;
    logic                            wready;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            arready;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
    logic                            cpu_clk;
    logic                            core_clk;
    logic                            osc;
    logic                            mreg;
    logic                            lreg;
    logic                            udrv;
    logic                            cpwr;
    logic                            crst_n;
    logic                            bkram;
  } lpm_regs_type;

  localparam lpm_regs_type RESET_STATE = '{
    state:    lpm_pkg::ST_RUN,
    ctrl:     lpm_pkg::CTRL_RESET,
    awready:  1'b1,
    wready:   1'b1,
    arready:  1'b1,
    cpu_clk:  1'b1,
    core_clk: 1'b1,
    osc:      1'b1,
    mreg:     1'b1,
    cpwr:     1'b1,
    crst_n:   1'b1,
    default:  '0
  };

  localparam logic [7:0] RESTART_LOAD =
    8'(lpm_pkg::WAKE_RESET_CYCLES - 1);

  lpm_regs_type r;
  lpm_regs_type next_r;
  lpm_pkg::lpm_mode_type mode;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic        sb_exit;

  wake_if w ();

  // ----------------------------------------------------------------
  // Wakeup synchroniser
  // ----------------------------------------------------------------
  wake_sync #(
    .LINE_CNT (LINE_CNT)
  ) u_sync (
    .clk                     (CLK),
    .rst_n                   (RST_N),
    .ce                      (CE),
    .ext_lines               (EXTERNAL_INTERRUPT_LINE),
    .supply_voltage_detector (SUPPLY_VOLTAGE_DETECTOR),
    .rtc_event               (RTC_EVENT),
    .usb_wake                (USB_WAKE),
    .eth_wake                (ETH_WAKE),
    .reset_pin_low           (RESET_PIN_LOW),
    .independent_watchdog    (INDEPENDENT_WATCHDOG),
    .wake_pin                (WAKE_PIN),
    .reg_bypass              (REG_BYPASS),
    .w                       (w)
  );

  // Map a byte address to a register: 0 ctrl, 1 status, 2 none
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == lpm_pkg::ADDR_CTRL) begin
      return 2'h0;
    end else if (a == lpm_pkg::ADDR_STATUS) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  // Selected target mode and readable words
  always_comb begin
    mode = lpm_pkg::lpm_mode_type'(
      r.ctrl[lpm_pkg::CTRL_MODE_LSB +: 2]);
    ctrl_word = {27'h0, r.ctrl};
    status_word = 32'h0;
    status_word[lpm_pkg::STAT_STATE_LSB +: 3] = r.state;
    status_word[lpm_pkg::STAT_REFUSE_BIT] = r.refused;
    status_word[lpm_pkg::STAT_SBWAKE_BIT] = r.sb_woke;
    status_word[lpm_pkg::STAT_BYPASS_BIT] = w.bypass;
  end

  assign sb_exit = w.pin_reset | w.wdg_reset | w.wake_rise
                   | w.rtc_event;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus slave, then mode sequencer, then clock and power controls
  always_comb begin
    next_r = r;
    if (CE) begin
      // Write address and data taken in either order
      if (AWVALID && r.awready) begin
        next_r.aw_got  = 1'b1;
        next_r.aw_addr = AWADDR;
      end
      if (WVALID && r.wready) begin
        next_r.w_got  = 1'b1;
        next_r.w_data = WDATA;
        next_r.w_strb = WSTRB;
      end
      if (r.bvalid && BREADY) begin
        next_r.bvalid = 1'b0;
      end
      if (next_r.aw_got && next_r.w_got && !next_r.bvalid) begin
        next_r.aw_got = 1'b0;
        next_r.w_got  = 1'b0;
        next_r.bvalid = 1'b1;
        next_r.bresp  = lpm_pkg::RESP_OKAY;
        case (reg_sel(next_r.aw_addr))
          2'h0: begin
            if (next_r.w_strb[0]) begin
              next_r.ctrl = next_r.w_data[lpm_pkg::CTRL_WIDTH-1:0];
            end
          end
          2'h1: begin
            // Write one clears a sticky flag
            if (next_r.w_strb[0] &&
                next_r.w_data[lpm_pkg::STAT_REFUSE_BIT]) begin
              next_r.refused = 1'b0;
            end
            if (next_r.w_strb[0] &&
                next_r.w_data[lpm_pkg::STAT_SBWAKE_BIT]) begin
              next_r.sb_woke = 1'b0;
            end
          end
          default: begin
            next_r.bresp = lpm_pkg::RESP_SLVERR;
          end
        endcase
      end
      next_r.awready = !next_r.aw_got;
      next_r.wready  = !next_r.w_got;

      // Read answers one cycle after the address is taken
      if (r.rvalid && RREADY) begin
        next_r.rvalid  = 1'b0;
        next_r.arready = 1'b1;
      end
      if (ARVALID && r.arready) begin
        next_r.arready = 1'b0;
        next_r.rvalid  = 1'b1;
        next_r.rresp   = lpm_pkg::RESP_OKAY;
        case (reg_sel(ARADDR))
          2'h0: next_r.rdata = ctrl_word;
          2'h1: next_r.rdata = status_word;
          default: begin
            next_r.rdata = 32'h0;
            next_r.rresp = lpm_pkg::RESP_SLVERR;
          end
        endcase
      end

      // Mode sequencer; hardware sets after the bus clear
      case (r.state)
        lpm_pkg::ST_RUN: begin
          // entry on request with selected mode
          if (LP_REQ) begin
            case (mode)
              lpm_pkg::MODE_SLEEP: next_r.state = lpm_pkg::ST_SLEEP;
              lpm_pkg::MODE_STOP:  next_r.state = lpm_pkg::ST_STOP;
              lpm_pkg::MODE_STANDBY: begin
                if (w.bypass) begin
                  next_r.refused = 1'b1;
                end else begin
                  next_r.state = lpm_pkg::ST_STANDBY;
                end
              end
              default: next_r.state = lpm_pkg::ST_RUN;
            endcase
          end
        end
        lpm_pkg::ST_SLEEP: begin
          if (PERIPH_EVENT || w.stop_wake) begin
            next_r.state = lpm_pkg::ST_RUN;
          end
        end
        lpm_pkg::ST_STOP: begin
          if (w.stop_wake) begin
            next_r.state = lpm_pkg::ST_RUN;
          end
        end
        lpm_pkg::ST_STANDBY: begin
          // control state lost, backup flags kept
          if (sb_exit) begin
            next_r.state   = lpm_pkg::ST_RESTART;
            next_r.cnt     = RESTART_LOAD;
            next_r.sb_woke = 1'b1;
            next_r.ctrl    = lpm_pkg::CTRL_RESET;
          end
        end
        lpm_pkg::ST_RESTART: begin
          // Hold core reset while the pin stays low
          if (w.pin_reset) begin
            next_r.cnt = RESTART_LOAD;
          end else if (r.cnt == 8'h00) begin
            next_r.state = lpm_pkg::ST_RUN;
          end else begin
            next_r.cnt = r.cnt - 8'h01;
          end
        end
        default: next_r.state = lpm_pkg::ST_RUN;
      endcase

      // processor clock runs only in run state
      next_r.cpu_clk  = next_r.state == lpm_pkg::ST_RUN;
      // core clocks gated in stop and standby
      next_r.core_clk = next_r.state != lpm_pkg::ST_STOP &&
                        next_r.state != lpm_pkg::ST_STANDBY;
      next_r.osc      = next_r.core_clk;
      next_r.cpwr     = next_r.state != lpm_pkg::ST_STANDBY;
      next_r.crst_n   = next_r.state != lpm_pkg::ST_STANDBY &&
                        next_r.state != lpm_pkg::ST_RESTART;
      if (next_r.state == lpm_pkg::ST_STOP) begin
        next_r.lreg = next_r.ctrl[lpm_pkg::CTRL_LPREG_BIT];
        next_r.mreg = !next_r.lreg;
        next_r.udrv = next_r.ctrl[lpm_pkg::CTRL_UDRV_BIT];
      end else begin
        next_r.lreg = 1'b0;
        next_r.mreg = next_r.cpwr;
        next_r.udrv = 1'b0;
      end
      // backup memory retention frozen in standby
      if (next_r.state != lpm_pkg::ST_STANDBY) begin
        next_r.bkram = next_r.ctrl[lpm_pkg::CTRL_BKRAM_BIT];
      end
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AWREADY = r.awready;
  assign WREADY  = r.wready;
  assign BVALID  = r.bvalid;
  assign BRESP   = r.bresp;
  assign ARREADY = r.arready;
  assign RVALID  = r.rvalid;
  assign RDATA   = r.rdata;
  assign RRESP   = r.rresp;
  assign CPU_CLK_EN  = r.cpu_clk;
  assign CORE_CLK_EN = r.core_clk;
  assign PLL_EN      = r.osc;
  assign INTERNAL_FAST_RC_OSC_EN      = r.osc;
  assign EXTERNAL_FAST_CRYSTAL_OSC_EN = r.osc;
  assign MAIN_REGULATOR_EN      = r.mreg;
  assign LOW_POWER_REGULATOR_EN = r.lreg;
  assign UNDER_DRIVE       = r.udrv;
  assign CORE_POWER_EN     = r.cpwr;
  assign CORE_RESET_N      = r.crst_n;
  assign BACKUP_RAM_RETAIN = r.bkram;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_sleep_cpu_only: assert property (
    r.state == lpm_pkg::ST_SLEEP |-> !CPU_CLK_EN && CORE_CLK_EN && PLL_EN)
    else $error("sleep gates more than the processor clock");
  a_sleep_wakeup: assert property (
    CE && r.state == lpm_pkg::ST_SLEEP && PERIPH_EVENT
    |=> r.state == lpm_pkg::ST_RUN && CPU_CLK_EN)
    else $error("peripheral event did not end sleep");
  a_stop_clocks: assert property (
    r.state == lpm_pkg::ST_STOP |-> !CORE_CLK_EN && !CPU_CLK_EN)
    else $error("core clock running in stop");
  a_stop_osc_off: assert property (
    r.state == lpm_pkg::ST_STOP |-> !PLL_EN && !INTERNAL_FAST_RC_OSC_EN
      && !EXTERNAL_FAST_CRYSTAL_OSC_EN)
    else $error("oscillator on in stop");
  a_stop_retain: assert property (
    r.state == lpm_pkg::ST_STOP |-> CORE_POWER_EN && CORE_RESET_N)
    else $error("state not retained in stop");
  a_stop_regulator: assert property (
    r.state == lpm_pkg::ST_STOP
    |-> LOW_POWER_REGULATOR_EN == r.ctrl[lpm_pkg::CTRL_LPREG_BIT]
      && MAIN_REGULATOR_EN != LOW_POWER_REGULATOR_EN
      && UNDER_DRIVE == r.ctrl[lpm_pkg::CTRL_UDRV_BIT])
    else $error("wrong regulator setting in stop");
  a_stop_wakeup: assert property (
    CE && r.state == lpm_pkg::ST_STOP && w.stop_wake
    |=> r.state == lpm_pkg::ST_RUN && CPU_CLK_EN)
    else $error("line event did not end stop");
  a_standby_off: assert property (
    r.state == lpm_pkg::ST_STANDBY |-> !CORE_POWER_EN
      && !MAIN_REGULATOR_EN && !LOW_POWER_REGULATOR_EN && !PLL_EN)
    else $error("core domain powered in standby");
  a_standby_lost: assert property (
    $rose(r.state == lpm_pkg::ST_RESTART)
    |-> r.ctrl == lpm_pkg::CTRL_RESET && !CORE_RESET_N && r.sb_woke)
    else $error("standby exit kept control state");
  a_standby_exit: assert property (
    CE && r.state == lpm_pkg::ST_STANDBY && w.wake_rise
    |=> r.state == lpm_pkg::ST_RESTART ##[1:40] CORE_RESET_N)
    else $error("wake pin did not end standby");
  a_no_bypass_sb: assert property (
    CE && r.state == lpm_pkg::ST_RUN && LP_REQ && w.bypass
      && mode == lpm_pkg::MODE_STANDBY
    |=> r.state == lpm_pkg::ST_RUN && r.refused)
    else $error("standby entered while bypassed");

  c_sleep_round: cover property (
    r.state == lpm_pkg::ST_SLEEP ##[1:20] r.state == lpm_pkg::ST_RUN);
  c_stop_round: cover property (
    r.state == lpm_pkg::ST_STOP ##[1:50] r.state == lpm_pkg::ST_RUN);
  c_standby_exit: cover property (
    $rose(r.state == lpm_pkg::ST_RESTART));
  c_refused: cover property ($rose(r.refused));

endmodule // lpm_ctrl

// [design/lpm_pkg.sv]
// Purpose: Shared constants and types for the low-power mode controller
// Assumes: 32-bit AXI4-Lite register access, CLK at 200 MHz
// Notes:   Register offsets are byte addresses
package lpm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_LPREG_BIT = 2;
  localparam int CTRL_UDRV_BIT  = 3;
  localparam int CTRL_BKRAM_BIT = 4;
  localparam int CTRL_WIDTH     = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Status register fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_REFUSE_BIT = 3;
  localparam int STAT_SBWAKE_BIT = 4;
  localparam int STAT_BYPASS_BIT = 5;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAKE_RESET_NS = 20;
  localparam int WAKE_RESET_CYCLES =
    (WAKE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP   = 2'h0,
    MODE_STOP    = 2'h1,
    MODE_STANDBY = 2'h2
  } lpm_mode_type;

  typedef enum logic [2:0] {
    ST_RUN     = 3'h0,
    ST_SLEEP   = 3'h1,
    ST_STOP    = 3'h2,
    ST_STANDBY = 3'h3,
    ST_RESTART = 3'h4
  } lpm_state_type;

endpackage

// [design/wake_if.sv]
// Purpose: Carries synchronised wakeup conditions to the mode controller
// Assumes: All signals are levels on CLK
// Notes:   Driven by wake_sync, read by lpm_ctrl
`timescale 1ns/1ps
interface wake_if;
  logic stop_wake;  // Any extended interrupt line event
  logic rtc_event;  // Clock alarm, wakeup, tamper or timestamp
  logic wake_rise;  // One-cycle rising edge of the wake pin
  logic pin_reset;  // Reset pin held low
  logic wdg_reset;  // Independent watchdog reset
  logic bypass;     // Core supply is external, regulator bypassed

  modport src (output stop_wake, rtc_event, wake_rise,
               output pin_reset, wdg_reset, bypass);
  modport dst (input stop_wake, rtc_event, wake_rise,
               input pin_reset, wdg_reset, bypass);
endinterface

// [design/wake_sync.sv]
// Purpose: Two-stage synchroniser and edge finder for wakeup pins
// Assumes: Inputs are asynchronous to clk
// Notes:   The decode logic reads the second stage and a delayed copy of the wake pin
`timescale 1ns/1ps
module wake_sync #(
  parameter int LINE_CNT = 16
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Asynchronous sources
  input  wire logic [LINE_CNT-1:0] ext_lines,
  input  wire logic                supply_voltage_detector,
  input  wire logic [3:0]          rtc_event,
  input  wire logic                usb_wake,
  input  wire logic                eth_wake,
  input  wire logic                reset_pin_low,
  input  wire logic                independent_watchdog,
  input  wire logic                wake_pin,
  input  wire logic                reg_bypass,
  // Synchronised conditions
  wake_if.src                      w
);

  localparam int W = LINE_CNT + 11;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic         wake_q;
  } sync_state_type;

  sync_state_type r;
  sync_state_type next_r;

  // ----------------------------------------------------------------
  // Sampling stages
  // ----------------------------------------------------------------
  // Shift every pin through two stages
  always_comb begin
    next_r = r;
    if (ce) begin
      next_r.s1 = {ext_lines, supply_voltage_detector, rtc_event,
                   usb_wake, eth_wake, reset_pin_low,
                   independent_watchdog, wake_pin, reg_bypass};
      next_r.s2 = r.s1;
      next_r.wake_q = r.s2[1];
    end
  end

  // Register the stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Decode the synchronised levels
  assign w.rtc_event = |r.s2[9:6];
  assign w.stop_wake = (|r.s2[W-1:11]) | r.s2[10] | w.rtc_event
                       | r.s2[5] | r.s2[4];
  assign w.pin_reset = ~r.s2[3];
  assign w.wdg_reset = r.s2[2];
  assign w.wake_rise = r.s2[1] & ~r.wake_q;
  assign w.bypass    = r.s2[0];

endmodule // wake_sync

// [sim/low_power_mode_controller_bench.sv]
// Purpose: Self-checking bench for the mode controller
// Assumes: Map and timing of lpm_pkg
// Notes:   Sources come from lpm_partner
`timescale 1ns/1ps
module low_power_mode_controller_bench;
  logic        clk, rst_n, byp, awv, wv, brd, arv, rrd, awr, wr_, bv, arr;
  logic        rv, lpq, pev, det, usb, eth, rpl, wdg, wkp, crst_n, ce;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt, rd_v, seed;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [15:0] ext;
  logic [3:0]  rtc;
  logic [9:0]  pw;
  logic [4:0]  c;
  int          error_cnt, num_checks, lo, cyc = 0, ks[4] = '{5, 6, 7, 2};

  lpm_ctrl #(.LINE_CNT(16)) dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .AWVALID(awv), .AWREADY(awr),
    .AWADDR(awa), .WVALID(wv), .WREADY(wr_), .WDATA(wd), .WSTRB(4'hF),
    .BVALID(bv), .BREADY(brd), .BRESP(bresp), .ARVALID(arv),
    .ARREADY(arr), .ARADDR(ara), .RVALID(rv), .RREADY(rrd), .RDATA(rdt),
    .RRESP(rresp), .LP_REQ(lpq), .PERIPH_EVENT(pev),
    .EXTERNAL_INTERRUPT_LINE(ext), .SUPPLY_VOLTAGE_DETECTOR(det),
    .RTC_EVENT(rtc), .USB_WAKE(usb), .ETH_WAKE(eth), .RESET_PIN_LOW(rpl),
    .INDEPENDENT_WATCHDOG(wdg), .WAKE_PIN(wkp), .REG_BYPASS(byp),
    .CPU_CLK_EN(pw[9]), .CORE_CLK_EN(pw[8]), .PLL_EN(pw[7]),
    .INTERNAL_FAST_RC_OSC_EN(pw[6]), .EXTERNAL_FAST_CRYSTAL_OSC_EN(pw[5]),
    .MAIN_REGULATOR_EN(pw[4]), .LOW_POWER_REGULATOR_EN(pw[3]),
    .UNDER_DRIVE(pw[2]), .CORE_POWER_EN(pw[1]), .CORE_RESET_N(crst_n),
    .BACKUP_RAM_RETAIN(pw[0]));
  lpm_partner p (
    .clk(clk), .lp_req(lpq), .periph_event(pev), .ext_line(ext),
    .det(det), .rtc(rtc), .usb(usb), .eth(eth), .reset_pin_low(rpl),
    .wdg(wdg), .wake_pin(wkp));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  // Controls per state: 0 run, 1 sleep, 2 stop, 3 standby
  function automatic logic [9:0] xp(input int m, input logic [4:0] k);
    case (m)
      0: return {5'h1F, 3'h4, 1'b1, k[4]};
      1: return {5'h0F, 3'h4, 1'b1, k[4]};
      2: return {5'h00, !k[2], k[2], k[3], 1'b1, k[4]};
      default: return {9'h000, k[4]};
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask

  // Bus write: hold each channel until taken, then the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, brd} <= {a, d, 3'h7};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    wr_r = bresp;
    brd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rrd} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    {rd_v, rd_r} = {rdt, rresp};
    rrd <= 1'b0;
  endtask

  task automatic go(input int m);
    wr(lpm_pkg::ADDR_CTRL, 32'(c));
    p.request();
    #1 chk("enter", 32'(pw), 32'(xp(m, c)));
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'hCDC8C46C;
    {rst_n, byp, awv, wv, brd, arv, rrd, awa, ara, wd} = 55'h0;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(lpm_pkg::ADDR_CTRL);
    chk("ctrl", rd_v, 32'h0);
    rd(8'h0C);
    chk("rresp", 32'(rd_r), 32'(lpm_pkg::RESP_SLVERR));
    wr(8'h0C, 32'h0);
    chk("bresp", 32'(wr_r), 32'(lpm_pkg::RESP_SLVERR));
    // Mode code 3 selects nothing: the request is ignored
    c = 5'h03;
    go(0);
    c = 5'($random(seed)) & 5'h1C;
    go(1);
    // Clock enable low freezes sleep although the event comes
    @(posedge clk) ce <= 1'b0;
    p.wake(8, 1, 4'h0);
    #1 chk("frozen", 32'(pw), 32'(xp(1, c)));
    @(posedge clk) ce <= 1'b1;
    p.wake(8, 1, 4'h0);
    repeat (3) @(posedge clk);
    #1 chk("sleep_exit", 32'(pw), 32'(xp(0, c)));
    // stop over regulator settings and sources
    for (int i = 0; i < 8; i++) begin
      c = {1'($random(seed)), 2'(i), 2'h1};
      go(2);
      p.wake(i % 5, 3, 4'($random(seed)));
      repeat (4) @(posedge clk);
      #1 chk("stop_exit", 32'(pw), 32'(xp(0, c)));
      rd(lpm_pkg::ADDR_CTRL);
      chk("kept", rd_v, 32'(c));
    end
    for (int j = 0; j < 4; j++) begin
      c = {1'($random(seed)), 4'h2};
      go(3);
      p.wake(0, 3, 4'h0);
      repeat (4) @(posedge clk);
      #1 chk("hold", 32'(pw), 32'(xp(3, c)));
      p.wake(ks[j], 3, 4'($random(seed)));
      lo = 0;
      for (int t = 0; t < 40 && pw[9] !== 1'b1; t++) begin
        @(posedge clk);
        lo += int'(crst_n === 1'b0);
      end
      chk("rst_len", 32'(lo >= lpm_pkg::WAKE_RESET_CYCLES), 32'h1);
      rd(lpm_pkg::ADDR_CTRL);
      chk("lost", rd_v, 32'h0);
      rd(lpm_pkg::ADDR_STATUS);
      chk("woke", rd_v & 32'h17, 32'h10);
      wr(lpm_pkg::ADDR_STATUS, 32'h10);
    end
    byp <= 1'b1;
    repeat (3) @(posedge clk);
    c = 5'h02;
    go(0);
    rd(lpm_pkg::ADDR_STATUS);
    chk("refused", rd_v & 32'h3F, 32'h28);
    finish_test();
  end
endmodule // low_power_mode_controller_bench

// [sim/lpm_partner.sv]
// Purpose: Processor and wakeup source model
// Assumes: Changes land just after a rising edge
// Notes:   One source is pulsed at a time
`timescale 1ns/1ps
module lpm_partner (
  // Clock
  input  wire logic   clk,
  // Processor side
  output logic        lp_req,
  output logic        periph_event,
  // Wakeup sources
  output logic [15:0] ext_line,
  output logic        det,
  output logic [3:0]  rtc,
  output logic        usb,
  output logic        eth,
  output logic        reset_pin_low,
  output logic        wdg,
  output logic        wake_pin
);
  logic [8:0] src;
  logic [3:0] sel;

  // Source levels; the reset pin idles high
  assign ext_line = src[0] ? 16'h0001 << sel : 16'h0000;
  assign rtc = src[2] ? 4'h1 << sel[1:0] : 4'h0;
  assign {det, usb, eth, wdg, wake_pin} = {src[1], src[4:3], src[7:6]};
  assign reset_pin_low = !src[5];
  assign periph_event = src[8];

  // Idle at time zero
  initial begin
    src = 9'h000;
    sel = 4'h0;
    lp_req = 1'b0;
  end

  task automatic request();
    @(posedge clk) lp_req <= 1'b1;
    @(posedge clk) lp_req <= 1'b0;
  endtask

  // Raise source k for n cycles
  task automatic wake(input int k, input int n, input logic [3:0] l);
    @(posedge clk);
    sel <= l;
    src[k] <= 1'b1;
    repeat (n) @(posedge clk);
    src[k] <= 1'b0;
  endtask
endmodule // lpm_partner
